/* File: rtl/obt_pkg.sv */
// obt_pkg: constants and carrier types for the octal registered transceiver
// assumes: a 32-bit Avalon-MM slave port with byte addresses
package obt_pkg;

    localparam int DATA_W = 8;
    localparam int LOG_DEPTH = 16;

    // register byte offsets
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_LOG = 4'h4;
    localparam logic [3:0] OFS_CTRL = 4'h8;

    // status fields
    localparam int ST_STORED_A_LSB = 0;
    localparam int ST_STORED_B_LSB = 8;
    localparam int ST_LOG_NONEMPTY = 16;
    localparam int ST_OVERFLOW = 17;
    localparam int ST_A_OE = 18;
    localparam int ST_B_OE = 19;

    // log word fields
    localparam int LG_DATA_LSB = 0;
    localparam int LG_SIDE = 8;
    localparam int LG_VALID = 9;

    // control fields and reset value
    localparam int CT_LOG_A_EN = 0;
    localparam int CT_LOG_B_EN = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    // bus answer state
    typedef enum logic [0:0] {
        OBT_BUS_IDLE = 1'b0,
        OBT_BUS_ACK = 1'b1
    } obt_bus_state_t;

    // control pins of the transceiver
    typedef struct packed {
        logic output_enable_n;
        logic drive_side_select;
        logic a_to_b_source_select;
        logic b_to_a_source_select;
    } obt_ctrl_pins_t;

    // one captured byte and the port it came from (1 = B)
    typedef struct packed {
        logic side;
        logic [DATA_W-1:0] data;
    } obt_log_t;

endpackage

/* File: rtl/obt_fifo.sv */
// obt_fifo: synchronous first-in first-out buffer with valid/ready
// assumes: one clock, synchronous active-low reset
`timescale 1ns/1ps
module obt_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        if (p == AW'(DEPTH - 1)) begin
            return '0;
        end
        return p + 1'b1;
    endfunction

    assign in_ready_o = (count != (AW + 1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always_comb begin
        next_wr_ptr = push ? wrap_inc(wr_ptr) : wr_ptr;
        next_rd_ptr = pop ? wrap_inc(rd_ptr) : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // storage has no reset
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

endmodule

/* File: rtl/obt_transceiver.sv */
// obt_transceiver: octal registered bus transceiver with capture log
// assumes: all pins synchronous to clk_i; capture clocks sampled as levels;
// the pad logic resolves each port from its output enable
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps

module obt_transceiver #(
    parameter int DATA_W = obt_pkg::DATA_W,
    parameter int LOG_DEPTH = obt_pkg::LOG_DEPTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // control pins
    input wire obt_pkg::obt_ctrl_pins_t ctrl_i,
    input wire logic a_to_b_capture_clock_i,
    input wire logic b_to_a_capture_clock_i,
    // port A
    input wire logic [DATA_W-1:0] a_i,
    output logic [DATA_W-1:0] a_o,
    output logic a_oe_o,
    // port B
    input wire logic [DATA_W-1:0] b_i,
    output logic [DATA_W-1:0] b_o,
    output logic b_oe_o,
    // capture log back-pressure
    output logic log_ready_o,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    localparam int LW = DATA_W + 1;

    // capture state
    logic clk_ab_prev;
    logic clk_ba_prev;
    logic [DATA_W-1:0] stored_a;
    logic [DATA_W-1:0] stored_b;
    logic next_clk_ab_prev;
    logic next_clk_ba_prev;
    logic [DATA_W-1:0] next_stored_a;
    logic [DATA_W-1:0] next_stored_b;
    logic cap_a;
    logic cap_b;

    // pin drive state
    logic [DATA_W-1:0] next_a_o;
    logic [DATA_W-1:0] next_b_o;
    logic next_a_oe;
    logic next_b_oe;

    // log and bus state
    obt_pkg::obt_bus_state_t bus_state;
    obt_pkg::obt_bus_state_t next_bus_state;
    logic [1:0] ctrl;
    logic [1:0] next_ctrl;
    logic overflow;
    logic next_overflow;
    logic [31:0] next_readdata;
    obt_pkg::obt_log_t log_in;
    logic [LW-1:0] log_out;
    logic log_in_valid;
    logic log_out_valid;
    logic log_pop;
    logic log_drop;
    logic accept;
    logic ctrl_wr;
    logic ovf_clr;

    function automatic logic is_addr(input logic [3:0] a,
                                     input logic [3:0] ofs);
        return a == ofs;
    endfunction

    // a 0-to-1 step between two clock samples
    function automatic logic rose_edge(input logic cur,
                                       input logic prev);
        return cur & ~prev;
    endfunction

    // status word as software reads it
    function automatic logic [31:0] status_word(
        input logic [DATA_W-1:0] sa,
        input logic [DATA_W-1:0] sb,
        input logic nonempty,
        input logic lost,
        input logic aoe,
        input logic boe
    );
        logic [31:0] w;
        w = '0;
        w[obt_pkg::ST_STORED_A_LSB +: DATA_W] = sa;
        w[obt_pkg::ST_STORED_B_LSB +: DATA_W] = sb;
        w[obt_pkg::ST_LOG_NONEMPTY] = nonempty;
        w[obt_pkg::ST_OVERFLOW] = lost;
        w[obt_pkg::ST_A_OE] = aoe;
        w[obt_pkg::ST_B_OE] = boe;
        return w;
    endfunction

    // log word: entry with its side, then the valid flag
    function automatic logic [31:0] log_word(input logic [LW-1:0] e,
                                             input logic v);
        logic [31:0] w;
        w = '0;
        w[obt_pkg::LG_DATA_LSB +: LW] = e;
        w[obt_pkg::LG_VALID] = v;
        return w;
    endfunction

    // capture: edge of the sampled capture clock loads the port
    assign cap_a = rose_edge(a_to_b_capture_clock_i, clk_ab_prev);
    assign cap_b = rose_edge(b_to_a_capture_clock_i, clk_ba_prev);

    always_comb begin
        next_clk_ab_prev = a_to_b_capture_clock_i;
        next_clk_ba_prev = b_to_a_capture_clock_i;
        // loads depend on nothing but the capture edge
        next_stored_a = cap_a ? a_i : stored_a;
        next_stored_b = cap_b ? b_i : stored_b;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            // a capture clock already high at release is no edge
            clk_ab_prev <= 1'b1;
            clk_ba_prev <= 1'b1;
        end else begin
            clk_ab_prev <= next_clk_ab_prev;
            clk_ba_prev <= next_clk_ba_prev;
        end
    end

    // storage keeps no reset value
    always_ff @(posedge clk_i) begin
        stored_a <= next_stored_a;
        stored_b <= next_stored_b;
    end

    // pin drive; stored paths read the next value so a capture shows at once
    always_comb begin
        next_a_oe = 1'b0;
        next_b_oe = 1'b0;
        next_a_o = a_o;
        next_b_o = b_o;
        if (!ctrl_i.output_enable_n) begin
            if (!ctrl_i.drive_side_select) begin
                next_a_oe = 1'b1;
                if (ctrl_i.b_to_a_source_select) begin
                    next_a_o = next_stored_b;
                end else begin
                    next_a_o = b_i;
                end
            end else begin
                next_b_oe = 1'b1;
                if (ctrl_i.a_to_b_source_select) begin
                    next_b_o = next_stored_a;
                end else begin
                    next_b_o = a_i;
                end
            end
        end
        // only one branch above can enable a port
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            a_oe_o <= 1'b0;
            b_oe_o <= 1'b0;
            a_o <= '0;
            b_o <= '0;
        end else begin
            a_oe_o <= next_a_oe;
            b_oe_o <= next_b_oe;
            a_o <= next_a_o;
            b_o <= next_b_o;
        end
    end

    // capture log: B wins when both are logged in one cycle, A is counted lost
    always_comb begin
        log_in_valid = 1'b0;
        log_in.side = 1'b0;
        log_in.data = a_i;
        if (cap_b && ctrl[obt_pkg::CT_LOG_B_EN]) begin
            log_in_valid = 1'b1;
            log_in.side = 1'b1;
            log_in.data = b_i;
        end else if (cap_a && ctrl[obt_pkg::CT_LOG_A_EN]) begin
            log_in_valid = 1'b1;
        end
    end

    assign log_drop = (log_in_valid & ~log_ready_o)
        | (cap_a & cap_b & ctrl[obt_pkg::CT_LOG_A_EN]
           & ctrl[obt_pkg::CT_LOG_B_EN]);

    obt_fifo #(
        .WIDTH(LW),
        .DEPTH(LOG_DEPTH)
    ) u_log (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(log_in_valid),
        .in_ready_o(log_ready_o),
        .in_data_i(log_in),
        .out_valid_o(log_out_valid),
        .out_ready_i(log_pop),
        .out_data_o(log_out)
    );

    // avalon slave: one wait cycle, then answer
    assign avs_waitrequest = (avs_read | avs_write)
        & (bus_state == obt_pkg::OBT_BUS_IDLE);
    assign accept = (avs_read | avs_write)
        & (bus_state == obt_pkg::OBT_BUS_ACK);
    assign log_pop = accept & avs_read
        & is_addr(avs_address, obt_pkg::OFS_LOG);

    assign ctrl_wr = accept & avs_write & avs_byteenable[0]
        & is_addr(avs_address, obt_pkg::OFS_CTRL);
    // the clear bit sits in byte lane 2
    assign ovf_clr = accept & avs_write & avs_byteenable[2]
        & is_addr(avs_address, obt_pkg::OFS_STATUS)
        & avs_writedata[obt_pkg::ST_OVERFLOW];

    // handshake
    always_comb begin
        next_bus_state = obt_pkg::OBT_BUS_IDLE;
        if ((avs_read || avs_write) && !accept) begin
            next_bus_state = obt_pkg::OBT_BUS_ACK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            bus_state <= obt_pkg::OBT_BUS_IDLE;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    // control and loss flag
    always_comb begin
        next_ctrl = ctrl_wr ? avs_writedata[1:0] : ctrl;
        next_overflow = overflow;
        if (ovf_clr) begin
            next_overflow = 1'b0;
        end
        // a new loss wins over the clear
        if (log_drop) begin
            next_overflow = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ctrl <= obt_pkg::CTRL_RESET;
            overflow <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            overflow <= next_overflow;
        end
    end

    // read data taken in the wait cycle, held until the next read
    always_comb begin
        next_readdata = avs_readdata;
        if (avs_read && !accept) begin
            next_readdata = '0;
            if (is_addr(avs_address, obt_pkg::OFS_STATUS)) begin
                next_readdata = status_word(stored_a, stored_b,
                    log_out_valid, overflow, a_oe_o, b_oe_o);
            end else if (is_addr(avs_address, obt_pkg::OFS_LOG)) begin
                next_readdata = log_word(log_out, log_out_valid);
            end else if (is_addr(avs_address, obt_pkg::OFS_CTRL)) begin
                next_readdata[1:0] = ctrl;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            avs_readdata <= '0;
        end else begin
            avs_readdata <= next_readdata;
        end
    end

endmodule

/* File: bench/obt_transceiver_properties.sv */
// obt_transceiver_properties: port checks for the transceiver
// assumes: bound into obt_transceiver, single clock domain
`timescale 1ns/1ps
module obt_transceiver_properties (
    // clock, reset and pins
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire obt_pkg::obt_ctrl_pins_t ctrl_i,
    input wire logic a_to_b_capture_clock_i,
    input wire logic b_to_a_capture_clock_i,
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    // driven side and bus
    input wire logic [7:0] a_o,
    input wire logic a_oe_o,
    input wire logic [7:0] b_o,
    input wire logic b_oe_o,
    input wire logic avs_read,
    input wire logic avs_waitrequest
);
    logic pa, pb;
    logic [7:0] sa, sb, next_sa, next_sb;
    // shadow copies of the storage registers
    always_comb begin
        next_sa = (a_to_b_capture_clock_i && !pa) ? a_i : sa;
        next_sb = (b_to_a_capture_clock_i && !pb) ? b_i : sb;
    end
    always_ff @(posedge clk_i) begin
        pa <= !rstn_i || a_to_b_capture_clock_i;
        pb <= !rstn_i || b_to_a_capture_clock_i;
        sa <= next_sa;
        sb <= next_sb;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    property p_one_drive;
        !(a_oe_o && b_oe_o);
    endproperty
    property p_idle;
        ctrl_i.output_enable_n |=> !a_oe_o && !b_oe_o;
    endproperty
    property p_side;
        !ctrl_i.output_enable_n |=> b_oe_o == $past(ctrl_i[2])
            && a_oe_o == !$past(ctrl_i[2]);
    endproperty
    property p_live_a;
        ctrl_i[3:2] == 2'h0 && !ctrl_i[0] |=> a_o == $past(b_i);
    endproperty
    property p_stored_a;
        ctrl_i[3:2] == 2'h0 && ctrl_i[0] |=> a_o == $past(next_sb);
    endproperty
    property p_live_b;
        ctrl_i[3:2] == 2'h1 && !ctrl_i[1] |=> b_o == $past(a_i);
    endproperty
    property p_stored_b;
        ctrl_i[3:2] == 2'h1 && ctrl_i[1] |=> b_o == $past(next_sa);
    endproperty
    property p_wait;
        $rose(avs_read) |-> s_one_wait;
    endproperty
    a_one_drive: assert property (p_one_drive)
        else $error("both ports driven");
    a_idle: assert property (p_idle)
        else $error("port driven while disabled");
    a_side: assert property (p_side)
        else $error("wrong port driven");
    a_live_a: assert property (p_live_a)
        else $error("port A not live B");
    a_stored_a: assert property (p_stored_a)
        else $error("port A not stored B");
    a_live_b: assert property (p_live_b)
        else $error("port B not live A");
    a_stored_b: assert property (p_stored_b)
        else $error("port B not stored A");
    a_wait: assert property (p_wait)
        else $error("read not one wait state");
endmodule
bind obt_transceiver obt_transceiver_properties u_props (.clk_i, .rstn_i,
    .ctrl_i, .a_to_b_capture_clock_i, .b_to_a_capture_clock_i, .a_i, .b_i,
    .a_o, .a_oe_o, .b_o, .b_oe_o, .avs_read, .avs_waitrequest);

/* File: bench/obt_bus_model.sv */
// obt_bus_model: far-side logic on ports A and B
// assumes: it drives a wire only while the transceiver leaves it free
`timescale 1ns/1ps
module obt_bus_model (
    // transceiver side
    input wire logic [7:0] a_dut_i,
    input wire logic a_oe_i,
    input wire logic [7:0] b_dut_i,
    input wire logic b_oe_i,
    // values the far side offers
    input wire logic [7:0] a_drv_i,
    input wire logic [7:0] b_drv_i,
    // resolved wires
    output logic [7:0] a_wire_o,
    output logic [7:0] b_wire_o
);
    assign a_wire_o = a_oe_i ? a_dut_i : a_drv_i;
    assign b_wire_o = b_oe_i ? b_dut_i : b_drv_i;
endmodule

/* File: bench/tb_top.sv */
// tb_top: table-driven test of obt_transceiver
// assumes: design under rtl/, far-side model beside it
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [3:0] ctrl;
        logic [7:0] a;
        logic [7:0] b;
        logic ca;
        logic cb;
        logic [1:0] oe;
        logic [7:0] v;
    } obt_row_t;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    obt_pkg::obt_ctrl_pins_t ctrl_i = 4'h8;
    logic ca = 1'b0, cb = 1'b0, a_oe_o, b_oe_o, log_ready_o;
    logic [7:0] a_drv = 8'h00, b_drv = 8'h00, a_i, b_i, a_o, b_o;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    int num_errors = 0, comparisons = 0, cycles = 0;
    logic [31:0] exp_log [3] = '{32'h322, 32'h355, 32'h288};
    obt_row_t rows [7] = '{'{4'h8, 8'h11, 8'h22, 1'b1, 1'b1, 2'h0, 8'h00},
        '{4'h0, 8'h00, 8'h33, 1'b0, 1'b0, 2'h2, 8'h33},
        '{4'h1, 8'h00, 8'h44, 1'b0, 1'b0, 2'h2, 8'h22},
        '{4'h1, 8'h00, 8'h55, 1'b0, 1'b1, 2'h2, 8'h55},
        '{4'h4, 8'h66, 8'h00, 1'b0, 1'b0, 2'h1, 8'h66},
        '{4'h6, 8'h77, 8'h00, 1'b0, 1'b0, 2'h1, 8'h11},
        '{4'h6, 8'h88, 8'h00, 1'b1, 1'b0, 2'h1, 8'h88}};
    obt_transceiver u_obt_transceiver (.clk_i, .rstn_i, .ctrl_i,
        .a_to_b_capture_clock_i(ca), .b_to_a_capture_clock_i(cb), .a_i,
        .a_o, .a_oe_o, .b_i, .b_o, .b_oe_o, .log_ready_o, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
        .avs_readdata, .avs_waitrequest);
    obt_bus_model u_obt_bus_model (.a_dut_i(a_o), .a_oe_i(a_oe_o),
        .b_dut_i(b_o), .b_oe_i(b_oe_o), .a_drv_i(a_drv), .b_drv_i(b_drv),
        .a_wire_o(a_i), .b_wire_o(b_i));
    always #10 clk_i = ~clk_i;
    task automatic check(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic apply(input obt_row_t r);
        @(posedge clk_i);
        ctrl_i <= r.ctrl;
        a_drv <= r.a;
        b_drv <= r.b;
        ca <= r.ca;
        cb <= r.cb;
        @(posedge clk_i);
        ca <= 1'b0;
        cb <= 1'b0;
        // one more edge: a turned-around port has stopped driving
        @(posedge clk_i);
        #1;
        check("oe", {30'h0, a_oe_o, b_oe_o}, {30'h0, r.oe});
        if (r.oe[1]) check("a_o", {24'h0, a_o}, {24'h0, r.v});
        if (r.oe[0]) check("b_o", {24'h0, b_o}, {24'h0, r.v});
    endtask
    task automatic bus(input logic w, input logic [3:0] ad,
                       input logic [31:0] d);
        @(posedge clk_i);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= ad;
        avs_writedata <= d;
        // hold the request until waitrequest is seen low at a rising edge
        do @(posedge clk_i); while (avs_waitrequest);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        foreach (rows[i]) apply(rows[i]);
        bus(1'b0, 4'h0, 32'h0);
        check("status", rd, 32'h000B5588);
        foreach (exp_log[i]) begin
            bus(1'b0, 4'h4, 32'h0);
            check("log", rd, exp_log[i]);
        end
        bus(1'b0, 4'h4, 32'h0);
        check("empty", {31'h0, rd[9]}, 32'h0);
        bus(1'b1, 4'hC, 32'hFFFFFFFF);
        bus(1'b0, 4'hC, 32'h0);
        check("unmapped", rd, 32'h0);
        bus(1'b1, 4'h8, 32'h1);
        bus(1'b0, 4'h8, 32'h0);
        check("ctrl", rd, 32'h1);
        bus(1'b1, 4'h0, 32'h20000);
        bus(1'b0, 4'h0, 32'h0);
        check("cleared", rd, 32'h00085588);
        for (int i = 0; i < 17; i++)
            apply('{4'h8, i[7:0], 8'h00, 1'b1, 1'b0, 2'h0, 8'h00});
        check("full", {31'h0, log_ready_o}, 32'h0);
        bus(1'b0, 4'h0, 32'h0);
        check("isolated", rd, 32'h00035510);
        for (int i = 0; i < 16; i++) begin
            bus(1'b0, 4'h4, 32'h0);
            check("drain", rd, {22'h0, 2'h2, i[7:0]});
        end
        check("ready", {31'h0, log_ready_o}, 32'h1);
        // ask for drive while reset is low: reset must win
        rstn_i <= 1'b0;
        ctrl_i <= 4'h0;
        @(posedge clk_i);
        ctrl_i <= 4'h8;
        #1;
        check("oe_rst", {30'h0, a_oe_o, b_oe_o}, 32'h0);
        @(posedge clk_i);
        rstn_i <= 1'b1;
        bus(1'b0, 4'h0, 32'h0);
        check("status_rst", rd, 32'h00005510);
        bus(1'b0, 4'h8, 32'h0);
        check("ctrl_rst", rd, 32'h3);
        end_sim();
    end
endmodule
